// >>> verilog/fcr_pkg.sv
// Register map, field positions, reset values and state codes of the front-end control bank
package fcr_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] REG_INPUT_CTRL  = 8'h00;
  localparam logic [7:0] REG_GAIN_REF    = 8'h01;
  localparam logic [7:0] REG_MODE        = 8'h02;
  localparam logic [7:0] REG_FIXED_TUNE  = 8'h03;
  localparam logic [7:0] REG_OVERRIDES   = 8'h04;
  localparam logic [7:0] REG_OSC_COMB    = 8'h05;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_INPUT_CTRL  = 8'hF0;
  localparam logic [7:0] RST_GAIN_REF    = 8'h60;
  localparam logic [7:0] RST_MODE        = 8'hB2;
  localparam logic [7:0] RST_FIXED_TUNE  = 8'hC8;
  localparam logic [7:0] RST_OVERRIDES   = 8'h08;
  localparam logic [7:0] RST_OSC_COMB    = 8'h1A;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MSB_INVERT_BIT   = 7;
  localparam int PATH_SELECT_BIT  = 6;
  localparam int RATE_SELECT_BIT  = 5;
  localparam int PHASE_SELECT_BIT = 4;
  localparam int DC_BYPASS_BIT    = 3;
  localparam int DC_HOLD_BIT      = 2;
  localparam int GAIN_HOLD_BIT    = 1;
  localparam int GAIN_REF_WE_BIT  = 0;
  localparam int MODE_MSB         = 7;
  localparam int MODE_LSB         = 5;
  localparam int POL_WE_BIT       = 5;
  localparam int POL_VALUE_BIT    = 4;
  localparam int SYNC_REINIT_BIT  = 1;
  localparam int MODE_WE_BIT      = 0;
  localparam int OSC_SEL_MSB      = 7;
  localparam int OSC_SEL_LSB      = 6;
  localparam int COMB_WE_BIT      = 5;
  localparam int COMB_OFF_LOW_BIT = 4;
  localparam int COMB_HALF_BIT    = 3;
  localparam int NOCOMB_GAIN_MSB  = 2;
  localparam int NOCOMB_GAIN_LSB  = 1;
  // ****************************************************************
  // Codes and datapath constants
  // ****************************************************************
  localparam logic [1:0] OSC_SYMBOL_RATE = 2'h0;
  localparam logic [1:0] OSC_DOUBLE_RATE = 2'h1;
  localparam logic [7:0] GAIN_UNITY      = 8'h40;
  localparam int         GAIN_FRAC_BITS  = 6;
  localparam int         DC_SHIFT        = 6;
  localparam int         NOCOMB_FRAC     = 4;
  localparam logic [2:0] NOCOMB_EXTRA_00 = 3'h0;
  localparam logic [2:0] NOCOMB_EXTRA_01 = 3'h2;
  localparam logic [2:0] NOCOMB_EXTRA_10 = 3'h3;
  localparam logic [2:0] NOCOMB_EXTRA_11 = 3'h4;
  // Sync lock reinit sequencer
  typedef enum logic [2:0] {
    SYNC_IDLE   = 3'b001,
    SYNC_ARMED  = 3'b010,
    SYNC_FORCED = 3'b100
  } fcr_sync_state_type;
endpackage

// >>> verilog/fcr_clock_divider.sv
// Symbol-rate and converter clock generation from the oscillator phase
`timescale 1ns/1ps
module fcr_clock_divider (
  input  wire logic       clk,                 // Device clock
  input  wire logic       sys_rst,             // Synchronous reset, active high
  input  wire logic [1:0] osc_rate_select,     // Oscillator rate code
  input  wire logic       rate_select,         // 1 forces symbol-rate converter clock
  input  wire logic       phase_select,        // 0 inverts converter clock
  output logic            symbol_rate_clock,   // Symbol-rate clock
  output logic            converter_clock_out  // Converter clock
);
  typedef struct packed {
    logic [1:0] phase_cnt;
    logic       sym_clk;
    logic       conv_clk;
  } fcr_div_state_type;

  fcr_div_state_type st;
  fcr_div_state_type nxt;

  // Oscillator phase and derived clocks
  always_comb begin
    nxt           = st;
    nxt.phase_cnt = st.phase_cnt + 2'h1;
    // Symbol clock is the oscillator or half of it
    nxt.sym_clk   = (osc_rate_select == fcr_pkg::OSC_DOUBLE_RATE) ? nxt.phase_cnt[1]
                                                                  : nxt.phase_cnt[0];
    if (rate_select || osc_rate_select != fcr_pkg::OSC_DOUBLE_RATE) begin
      nxt.conv_clk = nxt.sym_clk;
    end else begin
      nxt.conv_clk = nxt.phase_cnt[0];
    end
    nxt.conv_clk = nxt.conv_clk ^ ~phase_select;
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign symbol_rate_clock   = st.sym_clk;
  assign converter_clock_out = st.conv_clk;
endmodule

// >>> verilog/fcr_frontend_control.sv
// Front-end control register bank with the synchronizer datapath it steers
`timescale 1ns/1ps
module fcr_frontend_control #(
  parameter int         W                 = 10,    // Sample width
  parameter int         COMB_DELAY        = 12,    // Comb filter tap distance
  parameter logic [7:0] GAIN_REF_INTERNAL = 8'h60  // Built-in AGC target
) (
  input  wire logic         clk,                      // Device clock
  input  wire logic         sys_rst,                  // Synchronous reset, active high
  input  wire logic         reg_wr_strobe,            // Register write pulse
  input  wire logic [7:0]   reg_wr_addr,              // Register address
  input  wire logic [7:0]   reg_wr_data,              // Register write data
  input  wire logic [W-1:0] ext_data_in,              // External sample pins
  input  wire logic [W-1:0] conv_data_in,             // Internal converter samples
  input  wire logic [2:0]   detected_mode,            // Internally detected mode
  input  wire logic         calc_polarity,            // Internally calculated polarity
  input  wire logic         comb_decision_low,        // Internal comb decision, 0 = on
  input  wire logic         sync_lock_internal_low,   // Internal sync lock, active low
  input  wire logic         field_sync,               // High during field sync
  output logic [W-1:0]      sample_out,               // Processed samples
  output logic [2:0]        modulation_mode,          // Effective mode
  output logic              polarity_out_true,        // Polarity pin
  output logic              polarity_out_inverted,    // Inverted polarity pin
  output logic              sync_lock_indication_low, // Sync lock, active low
  output logic              comb_active,              // Comb filter in use
  output logic              symbol_rate_clock,        // Symbol-rate clock
  output logic              converter_clock_out       // Converter clock
);
  localparam int ACC_W = W + fcr_pkg::DC_SHIFT;
  localparam int SAT_W = W + 9;
  localparam logic signed [SAT_W-1:0] MAXV = SAT_W'((1 << (W - 1)) - 1);
  localparam logic signed [SAT_W-1:0] MINV = SAT_W'(-(1 << (W - 1)));

  typedef struct packed {
    logic [7:0]                    r0;
    logic [7:0]                    r1;
    logic [7:0]                    r2;
    logic [7:0]                    r3;
    logic [7:0]                    r4;
    logic [7:0]                    r5;
    logic [W-1:0]                  ext_s1;
    logic [W-1:0]                  ext_s2;
    logic [W-1:0]                  conv_s1;
    logic [W-1:0]                  conv_s2;
    logic [W-1:0]                  in_reg;
    logic [ACC_W-1:0]              dc_acc;
    logic [W-1:0]                  dc_out;
    logic [7:0]                    gain;
    logic [W-1:0]                  agc_out;
    logic [W-1:0]                  pol_out;
    logic [COMB_DELAY-1:0][W-1:0]  comb_line;
    logic [W-1:0]                  sample;
    logic [2:0]                    mode;
    logic                          pol_true;
    logic                          pol_inv;
    logic                          comb_on;
    logic                          sync_low;
    fcr_pkg::fcr_sync_state_type   sync_state;
  } fcr_state_type;

  fcr_state_type st;
  fcr_state_type nxt;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Register write hit
  function automatic logic fcr_wr_hit(input logic [7:0] addr, input logic [7:0] offs);
    return reg_wr_strobe && (addr == offs);
  endfunction

  // Sign extension to the working width
  function automatic logic signed [SAT_W-1:0] fcr_sext(input logic [W-1:0] x);
    return {{(SAT_W - W){x[W-1]}}, x};
  endfunction

  // Clamp to sample range
  function automatic logic [W-1:0] fcr_sat(input logic signed [SAT_W-1:0] v);
    logic [W-1:0] r;
    if (v > MAXV) begin
      r = MAXV[W-1:0];
    end else if (v < MINV) begin
      r = MINV[W-1:0];
    end else begin
      r = v[W-1:0];
    end
    return r;
  endfunction

  // Non-comb gain, extra sixteenths above unity
  function automatic logic [2:0] fcr_nocomb_extra(input logic [1:0] sel);
    logic [2:0] k;
    case (sel)
      2'h0:    k = fcr_pkg::NOCOMB_EXTRA_00;
      2'h1:    k = fcr_pkg::NOCOMB_EXTRA_01;
      2'h2:    k = fcr_pkg::NOCOMB_EXTRA_10;
      default: k = fcr_pkg::NOCOMB_EXTRA_11;
    endcase
    return k;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic                     path_ext;
  logic [W-1:0]             sel_data;
  logic signed [ACC_W-1:0]  dc_est_full;
  logic [W-1:0]             dc_est;
  logic signed [SAT_W-1:0]  prod;
  logic [W-1:0]             agc_mag;
  logic [7:0]               agc_target;
  logic [2:0]               mode_eff;
  logic                     pol_eff;
  logic                     comb_eff;
  logic signed [SAT_W-1:0]  comb_diff;
  logic signed [SAT_W-1:0]  nocomb_val;

  always_comb begin
    nxt = st;
    // Register writes
    if (fcr_wr_hit(reg_wr_addr, fcr_pkg::REG_INPUT_CTRL)) nxt.r0 = reg_wr_data;
    if (fcr_wr_hit(reg_wr_addr, fcr_pkg::REG_GAIN_REF))   nxt.r1 = reg_wr_data;
    if (fcr_wr_hit(reg_wr_addr, fcr_pkg::REG_MODE))       nxt.r2 = reg_wr_data;
    if (fcr_wr_hit(reg_wr_addr, fcr_pkg::REG_FIXED_TUNE)) nxt.r3 = reg_wr_data;
    if (fcr_wr_hit(reg_wr_addr, fcr_pkg::REG_OVERRIDES))  nxt.r4 = reg_wr_data;
    if (fcr_wr_hit(reg_wr_addr, fcr_pkg::REG_OSC_COMB))   nxt.r5 = reg_wr_data;

    // Two-stage capture of sample pins
    nxt.ext_s1  = ext_data_in;
    nxt.ext_s2  = st.ext_s1;
    nxt.conv_s1 = conv_data_in;
    nxt.conv_s2 = st.conv_s1;

    path_ext = ~st.r0[fcr_pkg::PATH_SELECT_BIT];
    sel_data = path_ext ? st.ext_s2 : st.conv_s2;
    nxt.in_reg = sel_data ^ {st.r0[fcr_pkg::MSB_INVERT_BIT], {(W - 1){1'b0}}};

    // DC estimate as a leaky average
    dc_est_full = $signed(st.dc_acc) >>> fcr_pkg::DC_SHIFT;
    dc_est      = dc_est_full[W-1:0];
    if (!st.r0[fcr_pkg::DC_HOLD_BIT]) begin
      nxt.dc_acc = st.dc_acc + ACC_W'(fcr_sext(st.in_reg)) - dc_est_full;
    end
    if (st.r0[fcr_pkg::DC_BYPASS_BIT]) begin
      nxt.dc_out = st.in_reg;
    end else begin
      nxt.dc_out = fcr_sat(fcr_sext(st.in_reg) - fcr_sext(dc_est));
    end

    // AGC gain stage, gain in 1/64 steps
    prod        = fcr_sext(st.dc_out) * $signed({{(SAT_W - 8){1'b0}}, st.gain});
    nxt.agc_out = fcr_sat(prod >>> fcr_pkg::GAIN_FRAC_BITS);
    agc_mag     = st.agc_out[W-1] ? (~st.agc_out + {{(W - 1){1'b0}}, 1'b1}) : st.agc_out;
    agc_target  = st.r0[fcr_pkg::GAIN_REF_WE_BIT] ? st.r1 : GAIN_REF_INTERNAL;
    if (!st.r0[fcr_pkg::GAIN_HOLD_BIT]) begin
      if (agc_mag > {{(W - 8){1'b0}}, agc_target} && st.gain != 8'h00) begin
        nxt.gain = st.gain - 8'h01;
      end else if (agc_mag < {{(W - 8){1'b0}}, agc_target} && st.gain != 8'hFF) begin
        nxt.gain = st.gain + 8'h01;
      end
    end

    pol_eff      = st.r4[fcr_pkg::POL_WE_BIT] ? st.r4[fcr_pkg::POL_VALUE_BIT] : calc_polarity;
    nxt.pol_true = pol_eff;
    nxt.pol_inv  = ~pol_eff;
    nxt.pol_out  = pol_eff ? fcr_sat(-fcr_sext(st.agc_out)) : st.agc_out;

    comb_eff    = st.r5[fcr_pkg::COMB_WE_BIT] ? ~st.r5[fcr_pkg::COMB_OFF_LOW_BIT]
                                              : ~comb_decision_low;
    nxt.comb_on = comb_eff;
    nxt.comb_line = {st.comb_line[COMB_DELAY-2:0], st.pol_out};
    comb_diff   = fcr_sext(st.pol_out) - fcr_sext(st.comb_line[COMB_DELAY-1]);
    nocomb_val  = ((fcr_sext(st.pol_out) <<< fcr_pkg::NOCOMB_FRAC)
                  + fcr_sext(st.pol_out)
                  * $signed({{(SAT_W - 3){1'b0}},
                             fcr_nocomb_extra(st.r5[fcr_pkg::NOCOMB_GAIN_MSB:
                                                    fcr_pkg::NOCOMB_GAIN_LSB])}))
                  >>> fcr_pkg::NOCOMB_FRAC;
    if (comb_eff) begin
      nxt.sample = st.r5[fcr_pkg::COMB_HALF_BIT] ? fcr_sat(comb_diff >>> 1) : fcr_sat(comb_diff);
    end else begin
      nxt.sample = fcr_sat(nocomb_val);
    end

    mode_eff = st.r4[fcr_pkg::MODE_WE_BIT] ? st.r2[fcr_pkg::MODE_MSB:fcr_pkg::MODE_LSB]
                                           : detected_mode;
    nxt.mode = mode_eff;

    case (st.sync_state)
      fcr_pkg::SYNC_IDLE: begin
        if (st.r4[fcr_pkg::SYNC_REINIT_BIT] && mode_eff != st.mode) begin
          nxt.sync_state = fcr_pkg::SYNC_ARMED;
        end
      end
      fcr_pkg::SYNC_ARMED: begin
        if (field_sync) begin
          nxt.sync_state = fcr_pkg::SYNC_FORCED;
        end
      end
      fcr_pkg::SYNC_FORCED: begin
        // A fresh mode change re-arms, so the forced low never lapses early
        if (st.r4[fcr_pkg::SYNC_REINIT_BIT] && mode_eff != st.mode) begin
          nxt.sync_state = fcr_pkg::SYNC_ARMED;
        end else if (!field_sync) begin
          nxt.sync_state = fcr_pkg::SYNC_IDLE;
        end
      end
      default: nxt.sync_state = fcr_pkg::SYNC_IDLE;
    endcase
    nxt.sync_low = (nxt.sync_state == fcr_pkg::SYNC_IDLE) ? sync_lock_internal_low : 1'b0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st            <= '0;
      st.r0         <= fcr_pkg::RST_INPUT_CTRL;
      st.r1         <= fcr_pkg::RST_GAIN_REF;
      st.r2         <= fcr_pkg::RST_MODE;
      st.r3         <= fcr_pkg::RST_FIXED_TUNE;
      st.r4         <= fcr_pkg::RST_OVERRIDES;
      st.r5         <= fcr_pkg::RST_OSC_COMB;
      st.gain       <= fcr_pkg::GAIN_UNITY;
      st.pol_inv    <= 1'b1;
      st.sync_low   <= 1'b1;
      st.sync_state <= fcr_pkg::SYNC_IDLE;
    end else begin
      st <= nxt;
    end
  end

  // Converter and symbol clocks
  fcr_clock_divider u_clock_divider (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .osc_rate_select     (st.r5[fcr_pkg::OSC_SEL_MSB:fcr_pkg::OSC_SEL_LSB]),
    .rate_select         (st.r0[fcr_pkg::RATE_SELECT_BIT]),
    .phase_select        (st.r0[fcr_pkg::PHASE_SELECT_BIT]),
    .symbol_rate_clock   (symbol_rate_clock),
    .converter_clock_out (converter_clock_out)
  );

  // Outputs straight from the state register
  assign sample_out               = st.sample;
  assign modulation_mode          = st.mode;
  assign polarity_out_true        = st.pol_true;
  assign polarity_out_inverted    = st.pol_inv;
  assign sync_lock_indication_low = st.sync_low;
  assign comb_active              = st.comb_on;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  msb_path_check_a: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
    |-> st.in_reg == (($past(st.r0[fcr_pkg::PATH_SELECT_BIT])
                       ? $past(conv_data_in, 3) : $past(ext_data_in, 3))
                      ^ {$past(st.r0[fcr_pkg::MSB_INVERT_BIT]), {(W - 1){1'b0}}}))
    else $error("sample select or MSB inversion wrong");

  clock_phase_a: assert property (
    !$past(sys_rst) && $past(st.r0[fcr_pkg::RATE_SELECT_BIT])
    |-> converter_clock_out == (symbol_rate_clock ^ ~$past(st.r0[fcr_pkg::PHASE_SELECT_BIT])))
    else $error("converter clock phase wrong");

  double_rate_a: assert property (
    !$past(sys_rst) && !st.r0[fcr_pkg::RATE_SELECT_BIT] && $stable(st.r0)
    && st.r5[fcr_pkg::OSC_SEL_MSB:fcr_pkg::OSC_SEL_LSB] == fcr_pkg::OSC_DOUBLE_RATE
    && $stable(st.r5)
    |=> converter_clock_out != $past(converter_clock_out))
    else $error("converter clock not at oscillator rate");

  dc_bypass_a: assert property (
    st.r0[fcr_pkg::DC_BYPASS_BIT] |=> st.dc_out == $past(st.in_reg))
    else $error("offset removal not bypassed");

  dc_hold_a: assert property (
    st.r0[fcr_pkg::DC_HOLD_BIT] |=> $stable(st.dc_acc))
    else $error("offset estimate moved while held");

  gain_hold_a: assert property (
    st.r0[fcr_pkg::GAIN_HOLD_BIT] |=> $stable(st.gain))
    else $error("gain moved while held");

  gain_ref_a: assert property (
    st.r0[fcr_pkg::GAIN_REF_WE_BIT] && !st.r0[fcr_pkg::GAIN_HOLD_BIT]
    && agc_mag > {{(W - 8){1'b0}}, st.r1} && st.gain != 8'h00
    |=> st.gain == $past(st.gain) - 8'h01)
    else $error("gain not steered to host reference");

  mode_override_a: assert property (
    st.r4[fcr_pkg::MODE_WE_BIT] |=> modulation_mode == $past(st.r2[7:5]))
    else $error("host mode not applied");

  polarity_pins_a: assert property (
    !$past(sys_rst)
    |-> polarity_out_true == ($past(st.r4[fcr_pkg::POL_WE_BIT])
                              ? $past(st.r4[fcr_pkg::POL_VALUE_BIT]) : $past(calc_polarity))
        && polarity_out_inverted != polarity_out_true)
    else $error("polarity pins wrong");

  sync_reinit_a: assert property (
    st.r4[fcr_pkg::SYNC_REINIT_BIT] && mode_eff != st.mode
    |=> !sync_lock_indication_low [*2])
    else $error("sync lock not forced on mode change");

  comb_override_a: assert property (
    st.r5[fcr_pkg::COMB_WE_BIT] |=> comb_active == !$past(st.r5[fcr_pkg::COMB_OFF_LOW_BIT]))
    else $error("comb override ignored");

  comb_half_a: assert property (
    comb_eff && st.r5[fcr_pkg::COMB_HALF_BIT]
    |=> fcr_sext(sample_out) == ($past(comb_diff) >>> 1))
    else $error("comb half gain wrong");

  nocomb_unity_a: assert property (
    !comb_eff && st.r5[2:1] == 2'h0 |=> sample_out == $past(st.pol_out))
    else $error("non-comb unity gain wrong");

  reinit_cov: cover property (st.sync_state == fcr_pkg::SYNC_FORCED);
  comb_half_cov: cover property (comb_eff && st.r5[fcr_pkg::COMB_HALF_BIT]);
  host_ref_cov: cover property (st.r0[fcr_pkg::GAIN_REF_WE_BIT] && st.gain != 8'h40);
  ext_path_cov: cover property (path_ext && st.r4[fcr_pkg::MODE_WE_BIT]);
endmodule

// >>> verif/fcr_host_model.sv
// Control bus host model that writes the front-end register bank
`timescale 1ns/1ps
module fcr_host_model (
  input  wire logic       clk,           // Device clock
  output logic            reg_wr_strobe, // Write pulse
  output logic [7:0]      reg_wr_addr,   // Register offset
  output logic [7:0]      reg_wr_data    // Write data
);
  // Idle bus at time zero
  initial begin
    reg_wr_strobe = 1'b0;
    reg_wr_addr   = 8'hFF;
    reg_wr_data   = 8'h00;
  end
  // One write over one edge; released bus shows the inverse, then one idle edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    reg_wr_strobe = 1'b1;
    reg_wr_addr   = a;
    reg_wr_data   = d;
    @(posedge clk);
    #1;
    reg_wr_strobe = 1'b0;
    reg_wr_addr   = ~a;
    reg_wr_data   = ~d;
    @(posedge clk);
    #1;
  endtask
  // Bring-up values for the tuning registers
  task automatic setup();
    write(8'h02, 8'hB6);
    write(8'h03, 8'hC8);
    write(8'h04, 8'h48);
    write(8'h05, 8'h1A);
  endtask
endmodule

// >>> verif/fcr_frontend_control_tb_top.sv
// Self-checking bench for the front-end control register bank
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module fcr_frontend_control_tb_top;
  logic       clk   = 1'b0;
  logic       sys_rst = 1'b1;
  logic       stb;
  logic [7:0] addr;
  logic [7:0] data;
  logic [9:0] ext   = '0;
  logic [9:0] conv  = '0;
  logic [2:0] det   = '0;
  logic       cpol  = 1'b0;
  logic       cdec  = 1'b0;
  logic       slk   = 1'b1;
  logic       fsync = 1'b0;
  logic [9:0] so;
  logic [2:0] m;
  logic       pt, pn, sl, ca, sc, cc;
  logic [7:0] r0, r2, r4, r5;
  logic [9:0] eh [8];
  logic [9:0] ch [8];
  int         seed = 58;
  int         fails = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         nc, ns, hi;
  fcr_host_model host (.clk(clk), .reg_wr_strobe(stb), .reg_wr_addr(addr), .reg_wr_data(data));
  fcr_frontend_control DUT (.clk(clk), .sys_rst(sys_rst), .reg_wr_strobe(stb),
    .reg_wr_addr(addr), .reg_wr_data(data), .ext_data_in(ext), .conv_data_in(conv),
    .detected_mode(det), .calc_polarity(cpol), .comb_decision_low(cdec),
    .sync_lock_internal_low(slk), .field_sync(fsync), .sample_out(so),
    .modulation_mode(m), .polarity_out_true(pt), .polarity_out_inverted(pn),
    .sync_lock_indication_low(sl), .comb_active(ca), .symbol_rate_clock(sc),
    .converter_clock_out(cc));
  // Clock, timeout and random sample stream
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    // Pins as this edge samples them
    eh[cyc % 8] = ext;
    ch[cyc % 8] = conv;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
    #1;
    ext  <= 10'($random(seed));
    conv <= 10'($random(seed));
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Expected mode, polarity and comb use from the overrides
  function automatic logic [4:0] exp_ctl(logic [7:0] a2, logic [7:0] a4, logic [7:0] a5,
                                         logic [2:0] d, logic p, logic c);
    exp_ctl[4:2] = a4[0] ? a2[7:5] : d;
    exp_ctl[1]   = a4[5] ? a4[4] : p;
    exp_ctl[0]   = a5[5] ? ~a5[4] : ~c;
  endfunction
  // Expected sample: bypass, gain 65/64, comb off, non-comb gain (16 + k) / 16
  function automatic logic [9:0] exp_smp(logic [9:0] x, logic inv, logic [1:0] g);
    int v;
    int k;
    v = $signed(x ^ {inv, 9'h000});
    v = (v * 65) >>> 6;
    v = (v > 511) ? 511 : ((v < -512) ? -512 : v);
    k = (g == 2'h0) ? 0 : int'(g) + 1;
    v = (v * (16 + k)) >>> 4;
    v = (v > 511) ? 511 : ((v < -512) ? -512 : v);
    return 10'(v);
  endfunction
  task automatic count_edges();
    logic pc, ps;
    nc = 0;
    ns = 0;
    repeat (16) begin
      pc = cc;
      ps = sc;
      tick(1);
      nc += int'(pc != cc);
      ns += int'(ps != sc);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(5);
    `CHK({so, m, pt, pn, sl, ca}, {10'h000, 3'h0, 4'h6})
    sys_rst = 1'b0;
    tick(2);
    `CHK(cc, sc)
    host.write(8'h04, 8'h49);
    `CHK(m, 3'h5)
    host.setup();
    r2 = 8'hB6;
    repeat (150) begin
      r2 = {3'($random(seed)), 5'h16};
      r4 = {2'b01, 2'($random(seed)), 3'b100, 1'($random(seed))};
      r5 = {2'b00, 5'($random(seed)), 1'b0};
      host.write(8'h02, r2);
      host.write(8'h04, r4);
      host.write(8'h05, r5);
      host.write(8'h84, 8'hFF);
      {det, cpol, cdec, slk} = 6'($random(seed));
      tick(3);
      `CHK({m, pt, ca}, exp_ctl(r2, r4, r5, det, cpol, cdec))
      `CHK({pn, sl}, {~pt, slk})
    end
    for (int o = 0; o < 2; o++) begin
      for (int k = 0; k < 4; k++) begin
        host.write(8'h05, {2'(o), 6'h1A});
        host.write(8'h00, {2'b11, 2'(k), 4'h0});
        tick(2);
        count_edges();
        `CHK(ns, (o == 1) ? 8 : 16)
        `CHK(nc, (o == 1 && k >= 2) ? 8 : 16)
        if (o == 0 || k >= 2) `CHK(cc, k[0] ? sc : ~sc)
      end
    end
    {det, slk} = 4'hB;
    host.write(8'h02, 8'hB6);
    host.write(8'h04, 8'h4B);
    tick(3);
    host.write(8'h02, 8'h36);
    tick(4);
    `CHK(sl, 1'b0)
    fsync = 1'b1;
    tick(3);
    `CHK(sl, 1'b0)
    fsync = 1'b0;
    tick(3);
    `CHK(sl, 1'b1)
    host.write(8'h04, 8'h49);
    host.write(8'h02, 8'hB6);
    repeat (4) begin
      tick(1);
      `CHK(sl, 1'b1)
    end
    // Mid-run reset; bypass and both holds land at the release edge
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    host.write(8'h00, 8'h3E);
    host.setup();
    host.write(8'h04, 8'h69);
    // Gain stepped once at the release edge, so the path runs at 65/64
    for (int i = 0; i < 16; i++) begin
      r0 = {i[0], i[1], 6'h3E};
      r5 = {4'h3, 1'b0, i[3:2], 1'b0};
      host.write(8'h05, r5);
      host.write(8'h00, r0);
      tick(6);
      repeat (8) begin
        tick(1);
        hi = (cyc - 6) % 8;
        `CHK(so, exp_smp(r0[6] ? ch[hi] : eh[hi], r0[7], r5[2:1]))
      end
    end
    // Host reference steering a running gain loop
    host.write(8'h01, 8'h20);
    host.write(8'h00, 8'hC1);
    tick(20);
    print_verdict();
  end
endmodule
